/* File: rtl/clock_reset_watchdog_control.sv */
// Clock selection, dividers, watchdog, reset collection and power supervision.
`timescale 1ns/1ps
`include "clkrst_consts.svh"
module clock_reset_watchdog_control
    import clkrst_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic [4:0] osc_level_in,
    input wire logic [2:0] clk_sel_in,
    output logic sys_clk_out,
    output logic [2:0] clk_src_out,
    output logic clk_switching_out,
    input wire logic freq_wr_in,
    input wire logic [5:0] freq_val_in,
    output logic [5:0] freq_out,
    input wire logic [7:0] nonvolatile_trim_latches_in,
    input wire logic flash_trim_wr_in,
    input wire logic [7:0] flash_trim_in,
    output logic [7:0] trim_out,
    input wire logic wdt_en_in,
    input wire logic wdt_src_in,
    input wire logic [15:0] wdt_limit_in,
    input wire logic wdt_clear_in,
    output logic [15:0] wdt_count_out,
    input wire logic external_reset_input_n_in,
    input wire logic sw_reset_in,
    input wire logic brownout_detector_in,
    input wire logic cause_clear_in,
    output logic sys_rst_n_out,
    output logic [4:0] reset_cause_out,
    input wire logic supply_ok_in,
    input wire logic [5:0] supply_level_in,
    input wire logic [5:0] supply_threshold_in,
    output logic supply_threshold_detector_irq_out,
    input wire logic mode_req_valid_in,
    input wire logic [2:0] mode_req_in,
    input wire logic wake_in,
    output logic [2:0] power_mode_out,
    input wire logic div_wr_in,
    input wire logic [3:0] div_idx_in,
    input wire logic [15:0] div_val_in,
    input wire logic div_half_in,
    input wire logic route_wr_in,
    input wire logic [3:0] route_idx_in,
    input wire logic [3:0] route_src_in,
    input wire logic [3:0] ana_sel_in,
    output logic ana_clk_out,
    output logic [15:0] div_clk_out
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [4:0] osc_s1;
        logic [4:0] osc_s2;
        logic [4:0] osc_s3;
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        sw_state_t sw;
        logic switching;
        logic [2:0] cur;
        logic gate;
        logic sys_clk;
        logic [5:0] freq;
        logic [7:0] trim;
        logic trim_done;
        logic [15:0] wdt_cnt;
        logic wdt_fire;
        logic [3:0] rst_cnt;
        logic sys_rst_n;
        logic [4:0] cause;
        pmode_t mode;
        logic below_threshold;
        logic threshold_irq;
        logic [11:0][15:0] div_val;
        logic [1:0] half;
        logic [1:0] phase;
        logic [11:0][15:0] cnt;
        logic [11:0] tick;
        logic [15:0][3:0] route;
        logic [3:0] ana_sel;
        logic ana_clk;
        logic [15:0] dig_clk;
    } state_t;

    state_t q;
    state_t d;

    function automatic logic [5:0] clamp6(input logic [5:0] v, input logic [5:0] lo, input logic [5:0] hi);
        clamp6 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Returns the tick flag above the next count value.
    function automatic logic [16:0] div_step(input logic [15:0] c, input logic [15:0] v, input logic ext);
        logic [16:0] lim;
        lim = {1'b0, v} + {16'h0000, ext};
        if (({1'b0, c} >= lim) || (c == 16'hffff))
        begin
            div_step = {1'b1, 16'h0000};
        end
        else
        begin
            div_step = {1'b0, c + 16'h0001};
        end
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        logic [16:0] st;
        logic ext;
        logic [2:0] wsrc;
        logic rst_req;
        st = '0;
        ext = 1'b0;
        wsrc = SRC_LOW_SPEED;
        rst_req = 1'b0;
        d = q;
        // Only the second stage and later are read by the logic.
        d.osc_s1 = osc_level_in;
        d.osc_s2 = q.osc_s1;
        d.osc_s3 = q.osc_s2;
        d.pin_s1 = {brownout_detector_in, external_reset_input_n_in};
        d.pin_s2 = q.pin_s1;

        // Break before make: the old source is gated at its low phase, the new one
        // is ungated at its own low phase, so no partial high level ever leaves.
        case (q.sw)
            SW_RUN:
            begin
                if ((clk_sel_in != q.cur) && (clk_sel_in <= SRC_PIN))
                begin
                    d.sw = SW_WAIT_OLD;
                end
            end
            SW_WAIT_OLD:
            begin
                if (!q.osc_s2[q.cur])
                begin
                    d.gate = 1'b0;
                    d.cur = clk_sel_in;
                    d.sw = SW_WAIT_NEW;
                end
            end
            SW_WAIT_NEW:
            begin
                if (!q.osc_s2[q.cur])
                begin
                    d.gate = 1'b1;
                    d.sw = SW_RUN;
                end
            end
            default:
            begin
                d.sw = SW_RUN;
            end
        endcase
        d.switching = (d.sw != SW_RUN);
        d.sys_clk = d.gate & q.osc_s2[d.cur];

        if (freq_wr_in)
        begin
            d.freq = clamp6(freq_val_in, `FREQ_MIN_MHZ, `FREQ_MAX_MHZ);
        end
        if (!q.trim_done)
        begin
            d.trim = nonvolatile_trim_latches_in;
            d.trim_done = 1'b1;
        end
        else if (flash_trim_wr_in)
        begin
            d.trim = flash_trim_in;
        end

        // Watchdog ticks on rising edges of the chosen slow oscillator.
        wsrc = wdt_src_in ? SRC_WATCH_XTAL : SRC_LOW_SPEED;
        d.wdt_fire = 1'b0;
        if (!wdt_en_in || wdt_clear_in || !q.sys_rst_n)
        begin
            d.wdt_cnt = 16'h0000;
        end
        else if (q.osc_s2[wsrc] && !q.osc_s3[wsrc])
        begin
            if (q.wdt_cnt >= wdt_limit_in)
            begin
                d.wdt_fire = 1'b1;
                d.wdt_cnt = 16'h0000;
            end
            else
            begin
                d.wdt_cnt = q.wdt_cnt + 16'h0001;
            end
        end

        // Cause bits: a new event wins over a clear in the same cycle.
        if (cause_clear_in)
        begin
            d.cause = 5'h00;
        end
        if (!q.pin_s2[0])
        begin
            d.cause[`CAUSE_EXT] = 1'b1;
        end
        if (sw_reset_in)
        begin
            d.cause[`CAUSE_SW] = 1'b1;
        end
        if (q.wdt_fire)
        begin
            d.cause[`CAUSE_WDT] = 1'b1;
        end
        if (q.pin_s2[1])
        begin
            d.cause[`CAUSE_BROWNOUT] = 1'b1;
        end
        rst_req = !q.pin_s2[0] || sw_reset_in || q.wdt_fire || q.pin_s2[1];
        if (rst_req)
        begin
            d.sys_rst_n = 1'b0;
            d.rst_cnt = `RST_HOLD_CYC;
        end
        else if (q.rst_cnt != 4'h0)
        begin
            d.rst_cnt = q.rst_cnt - 4'h1;
        end
        else
        begin
            d.sys_rst_n = 1'b1;
        end

        // Threshold detector: one pulse per fall below the programmed level.
        d.below_threshold = supply_level_in < clamp6(supply_threshold_in, `THRESH_MIN_DV, `THRESH_MAX_DV);
        d.threshold_irq = d.below_threshold && !q.below_threshold;

        if (!q.sys_rst_n)
        begin
            d.mode = PM_ACTIVE;
        end
        else if (mode_req_valid_in && supply_ok_in && (mode_req_in <= PM_STOP))
        begin
            d.mode = pmode_t'(mode_req_in);
        end
        else if (wake_in && (q.mode != PM_STOP))
        begin
            d.mode = PM_ACTIVE;
        end

        if (div_wr_in && (div_idx_in < `NUM_DIV))
        begin
            d.div_val[div_idx_in] = div_val_in;
            if (div_idx_in >= `FIRST_HALF_DIV)
            begin
                d.half[1'(div_idx_in - `FIRST_HALF_DIV)] = div_half_in;
            end
        end
        for (int i = 0; i < `NUM_DIV; i++)
        begin
            ext = 1'b0;
            if (i >= `FIRST_HALF_DIV)
            begin
                ext = q.half[1'(i - `FIRST_HALF_DIV)] & q.phase[1'(i - `FIRST_HALF_DIV)];
            end
            st = div_step(q.cnt[i], q.div_val[i], ext);
            d.cnt[i] = st[15:0];
            d.tick[i] = st[16];
            if ((i >= `FIRST_HALF_DIV) && st[16])
            begin
                d.phase[1'(i - `FIRST_HALF_DIV)] = ~q.phase[1'(i - `FIRST_HALF_DIV)];
            end
        end
        if (route_wr_in)
        begin
            d.route[route_idx_in] = route_src_in;
        end
        d.ana_sel = ana_sel_in;
        // The analog output sees a tick one cycle before any digital output does.
        d.ana_clk = (q.ana_sel < `NUM_DIV) ? d.tick[q.ana_sel] : 1'b0;
        for (int k = 0; k < `NUM_OUT_CLK; k++)
        begin
            d.dig_clk[k] = (q.route[k] < `NUM_DIV) ? q.tick[q.route[k]] : 1'b0;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    // The cause record and trim load only on power-on, so other resets leave them.
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            q <= '0;
            q.freq <= `FREQ_RESET_MHZ;
            q.gate <= 1'b1;
            q.pin_s1 <= 2'b01;
            q.pin_s2 <= 2'b01;
            q.cause <= 5'h01;
            q.rst_cnt <= `RST_HOLD_CYC;
        end
        else
        begin
            q <= d;
        end
    end

    assign sys_clk_out = q.sys_clk;
    assign clk_src_out = q.cur;
    assign clk_switching_out = q.switching;
    assign freq_out = q.freq;
    assign trim_out = q.trim;
    assign wdt_count_out = q.wdt_cnt;
    assign sys_rst_n_out = q.sys_rst_n;
    assign reset_cause_out = q.cause;
    assign supply_threshold_detector_irq_out = q.threshold_irq;
    assign power_mode_out = q.mode;
    assign ana_clk_out = q.ana_clk;
    assign div_clk_out = q.dig_clk;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    chk_clk_gated_off: assert property ($rose(q.gate) |-> !sys_clk_out)
        else $error("clock ungated during a high phase");
    chk_freq_range: assert property (freq_out >= `FREQ_MIN_MHZ && freq_out <= `FREQ_MAX_MHZ)
        else $error("main oscillator setting out of range");
    chk_wdt_reset: assert property (q.wdt_fire |=> !sys_rst_n_out && reset_cause_out[`CAUSE_WDT])
        else $error("watchdog timeout gave no reset");
    chk_brownout_reset: assert property (q.pin_s2[1]
        |=> !sys_rst_n_out ##0 reset_cause_out[`CAUSE_BROWNOUT])
        else $error("brownout gave no reset");
    chk_cause_sticky: assert property (!cause_clear_in
        |=> (reset_cause_out & $past(reset_cause_out)) == $past(reset_cause_out))
        else $error("reset cause bit lost");
    chk_rst_hold: assert property ($rose(sys_rst_n_out) |-> $past(q.rst_cnt) == 4'h0 && !$past(sw_reset_in))
        else $error("reset released early");
    chk_threshold_pulse: assert property (supply_threshold_detector_irq_out
        |=> !supply_threshold_detector_irq_out)
        else $error("threshold interrupt held");
    chk_mode_hold: assert property (sys_rst_n_out && !supply_ok_in && !wake_in
        && power_mode_out == PM_ACTIVE |=> power_mode_out == PM_ACTIVE)
        else $error("mode entered on poor supply");
    chk_ana_lead: assert property (q.ana_sel == q.route[0] && $stable(q.route[0])
        && $stable(q.ana_sel) && ana_clk_out |=> div_clk_out[0])
        else $error("digital clock not one cycle after analog");
endmodule

/* File: rtl/clkrst_consts.svh */
// Constants for the clock, reset and watchdog controller.
`ifndef CLKRST_CONSTS_SVH
`define CLKRST_CONSTS_SVH
`define FREQ_RESET_MHZ 6'h18
`define FREQ_MIN_MHZ 6'h03
`define FREQ_MAX_MHZ 6'h30
`define THRESH_MIN_DV 6'h12
`define THRESH_MAX_DV 6'h2d
`define RST_HOLD_CYC 4'hf
`define NUM_DIV 12
`define NUM_HALF_DIV 2
`define FIRST_HALF_DIV 4'ha
`define NUM_OUT_CLK 16
`define CAUSE_POR 0
`define CAUSE_EXT 1
`define CAUSE_SW 2
`define CAUSE_WDT 3
`define CAUSE_BROWNOUT 4
`endif

/* File: rtl/clkrst_pkg.sv */
// Types shared by the clock, reset and watchdog controller.
package clkrst_pkg;
    typedef enum logic [2:0] {
        SRC_MAIN = 3'b000,
        SRC_LOW_SPEED = 3'b001,
        SRC_FAST_XTAL = 3'b010,
        SRC_WATCH_XTAL = 3'b011,
        SRC_PIN = 3'b100
    } clk_src_t;
    typedef enum logic [1:0] {
        SW_RUN = 2'b00,
        SW_WAIT_OLD = 2'b01,
        SW_WAIT_NEW = 2'b10
    } sw_state_t;
    typedef enum logic [2:0] {
        PM_ACTIVE = 3'b000,
        PM_SLEEP = 3'b001,
        PM_DEEP_SLEEP = 3'b010,
        PM_HIBERNATE = 3'b011,
        PM_STOP = 3'b100
    } pmode_t;
endpackage

/* File: tb/osc_model.sv */
// Model of the five clock sources that feed the selector and the watchdog.
`timescale 1ns/1ps
module osc_model
(
    input wire logic ref_clk_in,
    output logic [4:0] osc_level_out
);
    // Half periods differ so that every switch meets sources of unrelated phase.
    int half_cyc[5] = '{2, 4, 3, 8, 5};
    int cnt[5] = '{0, 0, 0, 0, 0};
    initial osc_level_out = 5'h00;
    always @(negedge ref_clk_in)
    begin
        for (int i = 0; i < 5; i++)
        begin
            cnt[i] = cnt[i] + 1;
            if (cnt[i] >= half_cyc[i])
            begin
                cnt[i] = 0;
                osc_level_out[i] <= ~osc_level_out[i];
            end
        end
    end
endmodule

/* File: tb/clock_reset_watchdog_control_test.sv */
// Self-checking testbench of the clock, reset and watchdog controller.
`timescale 1ns/1ps
module clock_reset_watchdog_control_test;
    logic ref_clk_in, arst_n_in, sys_clk_out, clk_switching_out, freq_wr_in, flash_trim_wr_in;
    logic wdt_en_in, wdt_src_in, wdt_clear_in, external_reset_input_n_in, sw_reset_in;
    logic brownout_detector_in, cause_clear_in, sys_rst_n_out, supply_ok_in, mode_req_valid_in;
    logic supply_threshold_detector_irq_out, wake_in, div_wr_in, div_half_in, route_wr_in, ana_clk_out;
    logic [2:0] clk_sel_in, clk_src_out, mode_req_in, power_mode_out;
    logic [3:0] div_idx_in, route_idx_in, route_src_in, ana_sel_in;
    logic [4:0] osc_level_in, reset_cause_out;
    logic [5:0] freq_val_in, freq_out, supply_level_in, supply_threshold_in;
    logic [7:0] nonvolatile_trim_latches_in, flash_trim_in, trim_out;
    logic [15:0] wdt_limit_in, wdt_count_out, div_val_in, div_clk_out;
    int fails = 0;
    int compares = 0;
    int hi = 0;
    int p, q;
    logic [11:0] freq_tab[5] = '{{6'h32, 6'h30}, {6'h02, 6'h03}, {6'h03, 6'h03}, {6'h30, 6'h30}, {6'h0a, 6'h0a}};
    logic [2:0] src_tab[5] = '{3'h2, 3'h4, 3'h3, 3'h1, 3'h0};
    logic mon_en = 0;
    logic ana_d;
    clock_reset_watchdog_control dut (.ref_clk_in, .arst_n_in, .osc_level_in, .clk_sel_in, .sys_clk_out,
        .clk_src_out, .clk_switching_out, .freq_wr_in, .freq_val_in, .freq_out, .nonvolatile_trim_latches_in,
        .flash_trim_wr_in, .flash_trim_in, .trim_out, .wdt_en_in, .wdt_src_in, .wdt_limit_in, .wdt_clear_in,
        .wdt_count_out, .external_reset_input_n_in, .sw_reset_in, .brownout_detector_in, .cause_clear_in,
        .sys_rst_n_out, .reset_cause_out, .supply_ok_in, .supply_level_in, .supply_threshold_in,
        .supply_threshold_detector_irq_out, .mode_req_valid_in, .mode_req_in, .wake_in, .power_mode_out,
        .div_wr_in, .div_idx_in, .div_val_in, .div_half_in, .route_wr_in, .route_idx_in, .route_src_in,
        .ana_sel_in, .ana_clk_out, .div_clk_out);
    osc_model sources (.ref_clk_in(ref_clk_in), .osc_level_out(osc_level_in));
    initial
    begin
        ref_clk_in = 0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    initial
    begin
        #100000;
        fails++;
        summarize();
    end
    // A one-cycle high phase on the selected clock is a runt pulse.
    always @(negedge ref_clk_in)
    begin
        ana_d <= ana_clk_out;
        if (sys_clk_out === 1'b1)
            hi++;
        else
        begin
            if (mon_en && hi > 0)
                check(hi > 1, 1);
            hi = 0;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    task automatic pulse(ref logic s, input logic v);
        s = v;
        cyc(1);
        s = ~v;
        cyc(1);
    endtask
    task automatic wait_val(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim)
        begin
            cyc(1);
            n++;
        end
    endtask
    task automatic gap(input int idx, output int g);
        int n;
        n = 1;
        cyc(1);
        while (div_clk_out[idx] !== 1'b1 && n < 100)
        begin
            cyc(1);
            n++;
        end
        g = n;
    endtask
    task automatic summarize();
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        {arst_n_in, clk_sel_in, freq_wr_in, freq_val_in, flash_trim_wr_in, flash_trim_in} = '0;
        {wdt_en_in, wdt_src_in, wdt_clear_in, sw_reset_in, brownout_detector_in, cause_clear_in} = '0;
        {mode_req_valid_in, mode_req_in, wake_in, div_wr_in, div_idx_in, div_val_in, div_half_in} = '0;
        {route_wr_in, route_idx_in, route_src_in, ana_sel_in} = '0;
        external_reset_input_n_in = 1;
        supply_ok_in = 1;
        supply_level_in = 6'h28;
        supply_threshold_in = 6'h1e;
        wdt_limit_in = 16'h0003;
        nonvolatile_trim_latches_in = 8'h5a;
        cyc(5);
        check(freq_out, 16'h0018);
        check(reset_cause_out, 16'h0001);
        check(sys_rst_n_out, 0);
        arst_n_in = 1;
        cyc(1);
        check(trim_out, 16'h005a);
        cyc(10);
        check(sys_rst_n_out, 0);
        wait_val(sys_rst_n_out, 1, 20);
        check(sys_rst_n_out, 1);
        flash_trim_in = 8'ha5;
        pulse(flash_trim_wr_in, 1);
        check(trim_out, 16'h00a5);
        foreach (freq_tab[i])
        begin
            freq_val_in = freq_tab[i][11:6];
            pulse(freq_wr_in, 1);
            check(freq_out, freq_tab[i][5:0]);
        end
        #3 arst_n_in = 0;
        #1 check(freq_out, 16'h0018);
        check(sys_rst_n_out, 0);
        cyc(1);
        arst_n_in = 1;
        wait_val(sys_rst_n_out, 1, 30);
        pulse(sw_reset_in, 1);
        check(sys_rst_n_out, 0);
        check(reset_cause_out, 16'h0005);
        wait_val(sys_rst_n_out, 1, 30);
        pulse(external_reset_input_n_in, 0);
        wait_val(sys_rst_n_out, 0, 5);
        check(reset_cause_out, 16'h0007);
        wait_val(sys_rst_n_out, 1, 30);
        pulse(brownout_detector_in, 1);
        wait_val(sys_rst_n_out, 0, 5);
        check(reset_cause_out, 16'h0017);
        wait_val(sys_rst_n_out, 1, 30);
        pulse(cause_clear_in, 1);
        check(reset_cause_out, 16'h0000);
        wdt_clear_in = 1;
        wdt_en_in = 1;
        cyc(100);
        check(sys_rst_n_out, 1);
        check(wdt_count_out, 16'h0000);
        wdt_clear_in = 0;
        wait_val(sys_rst_n_out, 0, 200);
        wdt_en_in = 0;
        check(reset_cause_out, 16'h0008);
        wait_val(sys_rst_n_out, 1, 30);
        wdt_src_in = 1;
        wdt_en_in = 1;
        cyc(40);
        check(sys_rst_n_out, 1);
        wait_val(sys_rst_n_out, 0, 100);
        check(sys_rst_n_out, 0);
        wdt_en_in = 0;
        wait_val(sys_rst_n_out, 1, 30);
        div_idx_in = 4'h0;
        div_val_in = 16'h0001;
        pulse(div_wr_in, 1);
        div_idx_in = 4'ha;
        div_val_in = 16'h0002;
        div_half_in = 1;
        pulse(div_wr_in, 1);
        route_src_in = 4'ha;
        route_idx_in = 4'h1;
        pulse(route_wr_in, 1);
        gap(0, p);
        gap(0, p);
        check(16'(p), 2);
        check(ana_d, 1);
        gap(1, p);
        gap(1, p);
        gap(1, q);
        check(16'(p + q), 7);
        mon_en = 1;
        foreach (src_tab[i])
        begin
            clk_sel_in = src_tab[i];
            cyc(2);
            check(clk_switching_out, 1);
            for (int n = 0; n < 100 && clk_switching_out !== 1'b0; n++)
                cyc(1);
            check(clk_src_out, src_tab[i]);
            cyc(20);
        end
        clk_sel_in = 3'h5;
        cyc(20);
        check(clk_src_out, 0);
        mon_en = 0;
        supply_level_in = 6'h14;
        wait_val(supply_threshold_detector_irq_out, 1, 5);
        check(supply_threshold_detector_irq_out, 1);
        cyc(1);
        check(supply_threshold_detector_irq_out, 0);
        supply_ok_in = 0;
        mode_req_in = 3'h1;
        pulse(mode_req_valid_in, 1);
        check(power_mode_out, 0);
        supply_ok_in = 1;
        mode_req_in = 3'h5;
        pulse(mode_req_valid_in, 1);
        check(power_mode_out, 0);
        for (int m = 1; m < 5; m++)
        begin
            mode_req_in = m[2:0];
            pulse(mode_req_valid_in, 1);
            check(power_mode_out, 16'(m));
            pulse(wake_in, 1);
            check(power_mode_out, 16'(m == 4 ? 4 : 0));
        end
        summarize();
    end
endmodule
